// File: lcc_pkg.sv
/*
  Shared constants for the lighting channel controller: timing,
  command codes, test-mode states, register offsets and reset values.
  Assumes a single system clock at CLK_HZ.
*/
package lcc_pkg;
  localparam int NCH       = 8;
  localparam int NSC       = 16;
  localparam int CLK_HZ    = 10_000_000;
  localparam int TICK_MS   = 1;
  localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
  localparam int RAMP_MS   = 10;
  localparam int LONG_MS   = 2000;
  localparam int BLINK_MS  = 500;
  localparam int IDLE_MS   = 300_000;
  localparam int DEB_MS    = 20;
  localparam int LONG_TK   = LONG_MS / TICK_MS;
  localparam int BLINK_TK  = BLINK_MS / TICK_MS;
  localparam int IDLE_TK   = IDLE_MS / TICK_MS;
  localparam int DEB_TK    = DEB_MS / TICK_MS;

  typedef enum logic [3:0] {
    CMD_SWITCH = 4'h0,
    CMD_DIM    = 4'h1,
    CMD_SETVAL = 4'h2,
    CMD_SLAVE  = 4'h3,
    CMD_BURN   = 4'h4,
    CMD_RECALL = 4'h5,
    CMD_STORE  = 4'h6,
    CMD_CDIM   = 4'h7,
    CMD_LEARN  = 4'h8
  } cmd_type;

  typedef enum logic [1:0] {
    T_IDLE   = 2'b00,
    T_ARM    = 2'b01,
    T_RUN    = 2'b10,
    T_DISARM = 2'b11
  } tst_type;

  localparam logic [1:0] SIDE_BOTH = 2'h0;
  localparam logic [1:0] SIDE_UP   = 2'h1;
  localparam logic [1:0] SIDE_DN   = 2'h2;

  localparam logic [9:0] A_CTRL = 10'h000;
  localparam logic [9:0] A_STAT = 10'h004;
  localparam logic [9:0] A_DYN  = 10'h008;
  localparam logic [9:0] A_LIM  = 10'h00c;
  localparam logic [9:0] A_LVL  = 10'h040;
  localparam logic [9:0] A_SCT  = 10'h080;
  localparam logic [9:0] A_SCN  = 10'h200;

  localparam logic [7:0]  LMIN_RST  = 8'h01;
  localparam logic [7:0]  LMAX_RST  = 8'hff;
  localparam logic [7:0]  DST_RST   = 8'hcc;
  localparam logic [7:0]  DOFF_RST  = 8'h1a;
  localparam logic [15:0] DHOLD_RST = 16'hbb80;
endpackage : lcc_pkg

// File: lighting_channel_controller.sv
/*
  Eight-channel lighting level controller: test button mode, scenes,
  dynamic mode, central scene dimming, follower mode, burn-in, faults.
  Assumes commands arrive as one-cycle strobes from bus-object logic on
  clk_sys, and fault and ballast-count inputs come from the line poller.
*/
`timescale 1ns/1ps
module lighting_channel_controller #(
  parameter int TICK_CYC = lcc_pkg::TICK_CYC,
  parameter int LONG_TK  = lcc_pkg::LONG_TK,
  parameter int BLINK_TK = lcc_pkg::BLINK_TK,
  parameter int IDLE_TK  = lcc_pkg::IDLE_TK
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            test_btn,
  input  wire logic            cmd_valid,
  input  wire logic [3:0]      cmd_code,
  input  wire logic [2:0]      cmd_ch,
  input  wire logic [7:0]      cmd_arg,
  input  wire logic            dl_active,
  input  wire logic [7:0]      lamp_fail,
  input  wire logic [7:0][4:0] bal_cnt,
  input  wire logic            cnt_valid,
  input  wire logic [9:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [31:0]     rdata,
  output logic      [7:0][7:0] ch_level,
  output logic                 led_green,
  output logic                 led_yellow,
  output logic      [7:0]      lamp_fault,
  output logic      [7:0]      bal_fault,
  output logic                 learn_busy
);
  localparam int NCH = lcc_pkg::NCH;
  localparam int DEB = lcc_pkg::DEB_TK;

  typedef struct packed {
    logic [1:0]            sy;
    logic                  btn;
    logic                  btn_p;
    logic [4:0]            deb;
    logic [16:0]           cyc;
    logic [3:0]            ms10;
    logic [11:0]           press;
    logic [18:0]           idle;
    logic [9:0]            blink;
    logic                  ph;
    logic                  green;
    lcc_pkg::tst_type      tst;
    logic [2:0]            tch;
    logic [7:0][7:0]       lvl;
    logic [7:0][7:0]       out;
    logic                  yel;
    logic [7:0]            mov;
    logic [7:0]            dir;
    logic [7:0]            slave;
    logic [7:0]            burn;
    logic [7:0]            dyn;
    logic [7:0][15:0]      hold;
    logic [7:0]            dst;
    logic [7:0]            doff;
    logic [15:0]           dhold;
    logic [7:0]            lmin;
    logic [7:0]            lmax;
    logic [15:0][7:0][8:0] scn;
    logic [15:0][15:0]     sct;
    logic [15:0]           prot;
    logic [15:0]           fade;
    logic [7:0][7:0]       ftgt;
    logic [7:0]            fmask;
    logic                  cact;
    logic                  cmov;
    logic                  cdir;
    logic [1:0]            cside;
    logic signed [9:0]     cpos;
    logic [7:0][7:0]       base;
    logic [7:0]            lampf;
    logic [7:0]            balf;
    logic [7:0][4:0]       bref;
    logic                  lbusy;
    logic [31:0]           rdata;
  } st_type;

  st_type s;
  st_type n;
  logic   ms;
  logic   stp;
  logic   rel;
  logic   lng;

  assign ms  = (s.cyc == 17'(TICK_CYC - 1));
  assign stp = ms && (s.ms10 == 4'(lcc_pkg::RAMP_MS - 1));
  assign rel = s.btn_p && !s.btn;
  assign lng = (s.press == 12'(LONG_TK));

  always_comb begin
    logic              hit;
    logic              free;
    logic [3:0]        sc;
    logic signed [9:0] hi;
    logic signed [9:0] lo;
    logic [8:0]        mag;
    logic [16:0]       prod;
    logic [7:0]        dl;
    logic [7:0]        setv;
    hit  = 1'b0;
    free = 1'b0;
    sc   = cmd_arg[3:0];
    hi   = 10'sd128;
    lo   = -10'sd128;
    mag  = 9'h0;
    prod = 17'h0;
    dl   = 8'h0;
    setv = 8'h0;
    n = s;
    n.rdata = 32'h0;
    // Millisecond and ramp-step time base, debounce, press timer
    n.cyc = ms ? 17'h0 : s.cyc + 17'h1;
    if (ms)
      n.ms10 = stp ? 4'h0 : s.ms10 + 4'h1;
    n.sy = {s.sy[0], test_btn};
    n.btn_p = s.btn;
    if (s.sy[1] == s.btn)
      n.deb = 5'h0;
    else if (ms) begin
      if (s.deb == 5'(DEB - 1)) begin
        n.btn = s.sy[1];
        n.deb = 5'h0;
      end else
        n.deb = s.deb + 5'h1;
    end
    // Cleared while released, so a saturated count never leaks into the
    // first cycle of the next press
    if (!s.btn)
      n.press = 12'h0;
    else if (s.btn && ms && !lng)
      n.press = s.press + 12'h1;
    if (s.tst != lcc_pkg::T_RUN || s.btn)
      n.idle = 19'h0;
    else if (ms)
      n.idle = s.idle + 19'h1;

    case (s.tst)
      lcc_pkg::T_IDLE: if (s.btn && lng) begin
        n.green = 1'b0;
        n.tst   = lcc_pkg::T_ARM;
      end
      lcc_pkg::T_ARM: if (rel) begin
        n.tst = lcc_pkg::T_RUN;
        n.tch = 3'h0;
      end
      lcc_pkg::T_RUN: begin
        if (s.btn && lng) begin
          n.green = 1'b1;
          n.tst   = lcc_pkg::T_DISARM;
        end else if (rel)
          n.tch = s.tch + 3'h1;
        else if (s.idle == 19'(IDLE_TK)) begin
          n.green = 1'b1;
          n.tst   = lcc_pkg::T_IDLE;
        end
      end
      lcc_pkg::T_DISARM: if (rel)
        n.tst = lcc_pkg::T_IDLE;
      default: n.tst = lcc_pkg::T_IDLE;
    endcase

    if (s.tst != lcc_pkg::T_RUN) begin
      n.blink = 10'h0;
      n.ph    = 1'b1;
    end else if (ms) begin
      if (s.blink == 10'(BLINK_TK - 1)) begin
        n.blink = 10'h0;
        n.ph    = !s.ph;
      end else
        n.blink = s.blink + 10'h1;
    end

    // Central dimming: position -128..128 (0..256 up only, -256..0 down only) maps each side onto its range
    if (s.cside == lcc_pkg::SIDE_UP) begin
      hi = 10'sd256;
      lo = 10'sd0;
    end else if (s.cside == lcc_pkg::SIDE_DN) begin
      hi = 10'sd0;
      lo = -10'sd256;
    end
    if (s.cact && s.cmov && stp) begin
      if (s.cdir && s.cpos != hi)
        n.cpos = s.cpos + 10'sd1;
      else if (!s.cdir && s.cpos != lo)
        n.cpos = s.cpos - 10'sd1;
      else
        n.cmov = 1'b0;
    end
    if (cmd_valid && cmd_code == lcc_pkg::CMD_CDIM) begin
      if (cmd_arg[2:0] == 3'h0)
        n.cmov = 1'b0;
      else begin
        n.cmov = 1'b1;
        n.cdir = cmd_arg[3];
        if (!s.cact) begin
          n.cact = 1'b1;
          n.cpos = 10'sd0;
          n.base = s.lvl;
          n.cside = (s.lvl == '0) ? lcc_pkg::SIDE_UP :
                    (&s.lvl) ? lcc_pkg::SIDE_DN : lcc_pkg::SIDE_BOTH;
        end
      end
    end else if (cmd_valid)
      n.cact = 1'b0; // Any other command ends the captured reference
    mag = n.cpos[9] ? 9'(-n.cpos) : n.cpos[8:0];

    if (stp && s.fade != 16'h0)
      n.fade = s.fade - 16'h1;
    if (cmd_valid && cmd_code == lcc_pkg::CMD_RECALL) begin
      n.fade = (s.sct[sc] == 16'h0) ? 16'h1 : s.sct[sc];
      n.mov  = 8'h0;
    end

    for (int c = 0; c < NCH; c++) begin
      hit  = cmd_valid && (cmd_ch == 3'(c));
      free = !(s.dyn[c] || s.slave[c] || s.burn[c]);
      if (stp && s.mov[c]) begin
        if (s.dir[c] && s.lvl[c] < s.lmax)
          n.lvl[c] = s.lvl[c] + 8'h1;
        else if (!s.dir[c] && s.lvl[c] > s.lmin)
          n.lvl[c] = s.lvl[c] - 8'h1;
        else
          n.mov[c] = 1'b0;
      end
      if (stp && s.hold[c] != 16'h0) begin
        n.hold[c] = s.hold[c] - 16'h1;
        if (s.hold[c] == 16'h1)
          n.lvl[c] = s.doff;
      end
      if (stp && s.fade == 16'h1 && s.fmask[c])
        n.lvl[c] = s.ftgt[c];
      if (s.cact && s.cmov && stp && free) begin
        prod = (n.cpos[9] ? s.base[c] : 8'hff - s.base[c]) * mag;
        dl = (s.cside == lcc_pkg::SIDE_BOTH) ? prod[14:7] : prod[15:8];
        if (mag[8] && s.cside != lcc_pkg::SIDE_BOTH)
          dl = 8'hff;
        n.lvl[c] = n.cpos[9] ? s.base[c] - dl : s.base[c] + dl;
      end
      if (cmd_valid && cmd_code == lcc_pkg::CMD_RECALL) begin
        n.ftgt[c]  = s.scn[sc][c][7:0];
        n.fmask[c] = !s.scn[sc][c][8] && free;
      end
      if (cmd_valid && cmd_code == lcc_pkg::CMD_STORE)
        n.scn[sc][c] = {1'b0, s.lvl[c]};

      if (cmd_arg == 8'h0)
        setv = 8'h0;
      else if (cmd_arg == 8'h1 || cmd_arg < s.lmin)
        setv = s.lmin;
      else if (cmd_arg == 8'hff)
        setv = 8'hff;
      else
        setv = (cmd_arg > s.lmax) ? s.lmax : cmd_arg;
      if (hit) begin
        case (cmd_code)
          lcc_pkg::CMD_SLAVE: if (!s.dyn[c])
            n.slave[c] = cmd_arg[0];
          lcc_pkg::CMD_BURN: if (!s.dyn[c]) begin
            n.burn[c] = cmd_arg[0];
            n.mov[c]  = 1'b0;
          end
          lcc_pkg::CMD_SWITCH: if (!s.slave[c]) begin
            n.mov[c] = 1'b0;
            if (s.dyn[c]) begin
              n.lvl[c]  = cmd_arg[0] ? s.dst : 8'h0;
              n.hold[c] = cmd_arg[0] ? s.dhold : 16'h0;
            end else
              n.lvl[c] = !cmd_arg[0] ? 8'h0 : s.burn[c] ? 8'hff : s.lmax;
          end
          lcc_pkg::CMD_DIM: if (free) begin
            n.mov[c] = (cmd_arg[2:0] != 3'h0);
            n.dir[c] = cmd_arg[3];
          end
          lcc_pkg::CMD_SETVAL: if (!s.dyn[c] && !s.burn[c]) begin
            n.lvl[c] = setv;
            n.mov[c] = 1'b0;
          end
          default: ;
        endcase
      end
      // Faults are per channel: the poller reports the line, not the unit
      n.balf[c] = !s.lbusy && (bal_cnt[c] < s.bref[c]);
      // Test overrides the outputs only; levels keep evolving underneath
      if (n.tst == lcc_pkg::T_RUN)
        n.out[c] = (n.tch == 3'(c)) ? 8'hff : 8'h00;
      else if (n.burn[c] && n.lvl[c] != 8'h0)
        n.out[c] = 8'hff;
      else
        n.out[c] = n.lvl[c];
    end

    n.lampf = lamp_fail;
    if (cmd_valid && cmd_code == lcc_pkg::CMD_LEARN)
      n.lbusy = 1'b1;
    if (s.lbusy && cnt_valid) begin
      n.bref  = bal_cnt;
      n.lbusy = 1'b0;
    end
    n.yel = (n.tst == lcc_pkg::T_RUN) ? n.ph :
            !((|n.lampf) || (|n.balf));

    if (wr) begin
      if (addr == lcc_pkg::A_CTRL)
        n.dyn = wdata[7:0];
      else if (addr == lcc_pkg::A_DYN)
        {n.dhold, n.doff, n.dst} = wdata;
      else if (addr == lcc_pkg::A_LIM)
        {n.lmax, n.lmin} = wdata[15:0];
      else if (addr[9:6] == lcc_pkg::A_SCT[9:6])
        {n.prot[addr[5:2]], n.sct[addr[5:2]]} = wdata[16:0];
      else if (addr[9] && !(dl_active && s.prot[addr[8:5]]))
        n.scn[addr[8:5]][addr[4:2]] = wdata[8:0];
    end
    if (rd) begin
      if (addr == lcc_pkg::A_CTRL)
        n.rdata = {24'h0, s.dyn};
      else if (addr == lcc_pkg::A_STAT)
        n.rdata = {8'h0, s.balf, s.lampf, 3'h0, s.lbusy, s.tch,
                   s.tst == lcc_pkg::T_RUN};
      else if (addr == lcc_pkg::A_DYN)
        n.rdata = {s.dhold, s.doff, s.dst};
      else if (addr == lcc_pkg::A_LIM)
        n.rdata = {16'h0, s.lmax, s.lmin};
      else if (addr[9:5] == lcc_pkg::A_LVL[9:5])
        n.rdata = {24'h0, s.out[addr[4:2]]};
      else if (addr[9:6] == lcc_pkg::A_SCT[9:6])
        n.rdata = {15'h0, s.prot[addr[5:2]], s.sct[addr[5:2]]};
      else if (addr[9])
        n.rdata = {23'h0, s.scn[addr[8:5]][addr[4:2]]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.green <= 1'b1;
      s.yel   <= 1'b1;
      s.ph    <= 1'b1;
      s.lmin  <= lcc_pkg::LMIN_RST;
      s.lmax  <= lcc_pkg::LMAX_RST;
      s.dst   <= lcc_pkg::DST_RST;
      s.doff  <= lcc_pkg::DOFF_RST;
      s.dhold <= lcc_pkg::DHOLD_RST;
    end else
      s <= n;
  end

  assign rdata      = s.rdata;
  assign ch_level   = s.out;
  assign led_green  = s.green;
  assign led_yellow = s.yel;
  assign lamp_fault = s.lampf;
  assign bal_fault  = s.balf;
  assign learn_busy = s.lbusy;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_green_long: assert property (
    s.tst == lcc_pkg::T_IDLE && s.btn && lng |=> !led_green)
    else $error("green not cleared by long press");
  chk_test_entry: assert property (
    s.tst == lcc_pkg::T_ARM && rel |=>
      ch_level[0] == 8'hff && ch_level[1] == 8'h00)
    else $error("test entry did not light channel zero only");
  chk_next_chan: assert property (
    s.tst == lcc_pkg::T_RUN && rel |=> s.tch == $past(s.tch) + 3'h1)
    else $error("short press did not advance channel");
  chk_blink_rate: assert property (
    s.tst == lcc_pkg::T_RUN && $past(s.tst) == lcc_pkg::T_RUN &&
      $changed(led_yellow) |-> $past(ms && s.blink == 10'(BLINK_TK - 1)))
    else $error("yellow toggled off its half period");
  chk_exit_long: assert property (
    s.tst == lcc_pkg::T_RUN && s.btn && lng |=>
      led_green ##1 (!rel || s.tst == lcc_pkg::T_DISARM))
    else $error("long press in test did not relight green");
  chk_idle_exit: assert property (
    s.tst == lcc_pkg::T_RUN && !s.btn && !rel &&
      s.idle == 19'(IDLE_TK) |=> s.tst == lcc_pkg::T_IDLE && led_green)
    else $error("inactivity did not end test");
  chk_resume: assert property (
    s.tst != lcc_pkg::T_RUN && !s.burn[0] |-> ch_level[0] == s.lvl[0])
    else $error("channel output differs from its level");
  chk_burn_full: assert property (
    s.tst != lcc_pkg::T_RUN && s.burn[1] && s.lvl[1] != 8'h0 |->
      ch_level[1] == 8'hff)
    else $error("burn-in channel not at full output");
  chk_zero_off: assert property (
    cmd_valid && cmd_code == lcc_pkg::CMD_SETVAL && cmd_arg == 8'h0 &&
      !s.dyn[cmd_ch] && !s.burn[cmd_ch] |=> s.lvl[$past(cmd_ch)] == 8'h0)
    else $error("zero setpoint did not switch off");
  chk_fault_led: assert property (
    s.tst != lcc_pkg::T_RUN && (|s.lampf) |-> !led_yellow)
    else $error("lamp fault not shown on yellow");
  chk_learn_ref: assert property (
    s.lbusy && cnt_valid |=> s.bref == $past(bal_cnt) && !learn_busy)
    else $error("ballast reference not captured");
  chk_stop_hold: assert property (
    cmd_valid && cmd_code == lcc_pkg::CMD_DIM && cmd_ch == 3'h0 &&
      cmd_arg[2:0] == 3'h0 && !s.dyn[0] && !s.slave[0] && !s.burn[0]
      |=> !s.mov[0] ##1 $stable(s.lvl[0]) || s.cact)
    else $error("stop did not halt the ramp");

  cov_test_run: cover property (s.tst == lcc_pkg::T_RUN && rel);
  cov_central:  cover property (s.cact && s.cmov && stp);
  cov_fade:     cover property (stp && s.fade == 16'h1 && |s.fmask);
endmodule : lighting_channel_controller

// File: ballast_model.sv
/*
  Behavioural model of the ballasts and the line poller on the eight
  output lines: per-channel lamp-fault status and present unit counts.
  Assumes the bench sets fault_set and missing on clk_sys edges.
*/
`timescale 1ns/1ps
module ballast_model #(
  parameter int UNITS = 3
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic [7:0]      fault_set,
  input  wire logic [7:0]      missing,
  output logic      [7:0]      lamp_fail,
  output logic      [7:0][4:0] bal_cnt,
  output logic                 cnt_valid
);
  logic [1:0] div_q;

  // Poll results refresh every cycle; cnt_valid pulses every fourth cycle, like a slow line scan
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= 2'h0;
      lamp_fail <= 8'h00;
      bal_cnt   <= '0;
      cnt_valid <= 1'b0;
    end else begin
      div_q     <= div_q + 2'h1;
      cnt_valid <= (div_q == 2'h3);
      lamp_fail <= fault_set;
      for (int c = 0; c < 8; c++) begin
        bal_cnt[c] <= 5'(UNITS) - {4'h0, missing[c]};
      end
    end
  end
endmodule : ballast_model

// File: lighting_channel_controller_tb.sv
/*
  Self-checking bench for the lighting channel controller.
  Assumes shortened timing: 4 cycles a tick, ramp step 10 ticks.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected %s: expected %h, seen %h", nm, e, g); \
  end end

module lighting_channel_controller_tb;
  logic            clk_sys, rst_n, test_btn, cmd_valid, dl_active;
  logic [3:0]      cmd_code;
  logic [2:0]      cmd_ch;
  logic [7:0]      cmd_arg, lamp_fail, lamp_fault, bal_fault, lvl;
  logic [7:0]      fault_set, missing;
  logic [7:0][4:0] bal_cnt;
  logic            cnt_valid, wr, rd, led_green, led_yellow, learn_busy, y0;
  logic [9:0]      addr;
  logic [31:0]     wdata, rdata, r;
  logic [7:0][7:0] ch_level;
  logic [7:0]      sv [4] = '{8'h80, 8'h00, 8'hff, 8'h01};
  int              fail_count, comparisons, cycles;

  lighting_channel_controller #(.TICK_CYC(4), .LONG_TK(40), .BLINK_TK(5),
    .IDLE_TK(200)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .test_btn(test_btn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_ch(cmd_ch), .cmd_arg(cmd_arg), .dl_active(dl_active),
    .lamp_fail(lamp_fail), .bal_cnt(bal_cnt), .cnt_valid(cnt_valid),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ch_level(ch_level), .led_green(led_green), .led_yellow(led_yellow),
    .lamp_fault(lamp_fault), .bal_fault(bal_fault),
    .learn_busy(learn_busy));

  ballast_model #(.UNITS(3)) far (.clk_sys(clk_sys), .rst_n(rst_n),
    .fault_set(fault_set), .missing(missing), .lamp_fail(lamp_fail),
    .bal_cnt(bal_cnt), .cnt_valid(cnt_valid));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic tk(input int n);
    repeat (n * 4) @(posedge clk_sys);
    #1;
  endtask : tk

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic cmd(input lcc_pkg::cmd_type c, input int ch,
                     input logic [7:0] a);
    @(posedge clk_sys);
    cmd_valid <= 1'b1; cmd_code <= c; cmd_ch <= 3'(ch); cmd_arg <= a;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
  endtask : cmd

  // Debounce is 20 ticks, so presses and releases last 25 ticks or more;
  // short presses stay under 40 ticks, long ones hold for 70
  task automatic btn(input logic v, input int n);
    @(posedge clk_sys);
    test_btn <= v;
    tk(n);
  endtask : btn

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Whole run is about 2900 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up;
    end
  end

  initial begin
    {rst_n, test_btn, cmd_valid, dl_active, wr, rd} = '0;
    {cmd_code, cmd_ch, cmd_arg, addr, wdata, fault_set, missing} = '0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK("green", 1'b1, led_green)
    `CHK("faults", 16'h0, {lamp_fault, bal_fault})
    `CHK("learn", 1'b0, learn_busy)
    rd_reg(lcc_pkg::A_STAT, r);
    `CHK("stat", 1'b0, r[0])
    rd_reg(lcc_pkg::A_DYN, r);
    `CHK("dyn", {lcc_pkg::DHOLD_RST, lcc_pkg::DOFF_RST, lcc_pkg::DST_RST}, r)
    rd_reg(lcc_pkg::A_LIM, r);
    `CHK("lim", {16'h0, lcc_pkg::LMAX_RST, lcc_pkg::LMIN_RST}, r)
    rd_reg(10'h010, r);
    `CHK("unmapped", 32'h0, r)
    done("reset");

    for (int i = 0; i < 4; i++) begin
      cmd(lcc_pkg::CMD_SETVAL, 3, sv[i]);
      lvl = (sv[i] == 8'h01) ? lcc_pkg::LMIN_RST : sv[i];
      `CHK("setval", lvl, ch_level[3])
      rd_reg(lcc_pkg::A_LVL + 10'd12, r);
      `CHK("level reg", {24'h0, lvl}, r)
    end
    done("setpoint");

    cmd(lcc_pkg::CMD_BURN, 2, 8'h01);
    cmd(lcc_pkg::CMD_SWITCH, 2, 8'h01);
    `CHK("burn on", 8'hff, ch_level[2])
    cmd(lcc_pkg::CMD_SETVAL, 2, 8'h40);
    cmd(lcc_pkg::CMD_DIM, 2, 8'h01);
    tk(25);
    `CHK("burn dim", 8'hff, ch_level[2])
    cmd(lcc_pkg::CMD_BURN, 2, 8'h00);
    cmd(lcc_pkg::CMD_SLAVE, 4, 8'h01);
    cmd(lcc_pkg::CMD_SWITCH, 4, 8'h01);
    `CHK("follower switch", 8'h00, ch_level[4])
    cmd(lcc_pkg::CMD_SETVAL, 4, 8'h77);
    `CHK("follower set", 8'h77, ch_level[4])
    cmd(lcc_pkg::CMD_SLAVE, 4, 8'h00);
    done("burn and follower");

    cmd(lcc_pkg::CMD_SETVAL, 1, 8'h40);
    cmd(lcc_pkg::CMD_DIM, 1, 8'h09);
    tk(25);
    cmd(lcc_pkg::CMD_DIM, 1, 8'h00);
    lvl = ch_level[1];
    `CHK("dim moved", 1'b1, lvl > 8'h40)
    tk(30);
    `CHK("dim held", lvl, ch_level[1])
    cmd(lcc_pkg::CMD_DIM, 0, 8'h00);
    `CHK("stop idle", 8'h00, ch_level[0])
    done("dim stop");

    wr_reg(lcc_pkg::A_SCN + 10'd64, 32'h55);
    wr_reg(lcc_pkg::A_SCN + 10'd68, 32'h100);
    wr_reg(lcc_pkg::A_SCT + 10'd8, 32'h10000);
    dl_active <= 1'b1;
    wr_reg(lcc_pkg::A_SCN + 10'd64, 32'h11);
    dl_active <= 1'b0;
    rd_reg(lcc_pkg::A_SCN + 10'd64, r);
    `CHK("protect", 32'h55, r)
    cmd(lcc_pkg::CMD_RECALL, 0, 8'h02);
    tk(12);
    `CHK("scene ch0", 8'h55, ch_level[0])
    `CHK("unchanged ch1", lvl, ch_level[1])
    `CHK("scene ch3", 8'h00, ch_level[3])
    cmd(lcc_pkg::CMD_STORE, 0, 8'h03);
    rd_reg(lcc_pkg::A_SCN + 10'd96, r);
    `CHK("store", 8'h55, r[7:0])
    done("scene");

    fault_set <= 8'h20;
    tk(1);
    `CHK("lamp fault", 8'h20, lamp_fault)
    `CHK("yellow fault", 1'b0, led_yellow)
    rd_reg(lcc_pkg::A_STAT, r);
    `CHK("stat fault", 8'h20, r[15:8])
    fault_set <= 8'h00;
    cmd(lcc_pkg::CMD_LEARN, 0, 8'h00);
    `CHK("learn busy", 1'b1, learn_busy)
    for (int i = 0; i < 50 && learn_busy !== 1'b0; i++) @(posedge clk_sys);
    #1 missing <= 8'h40;
    tk(2);
    `CHK("ballast", 8'h40, bal_fault)
    `CHK("learn end", 1'b0, learn_busy)
    missing <= 8'h00;
    tk(2);
    done("faults");

    btn(1'b1, 70);
    `CHK("green long", 1'b0, led_green)
    rd_reg(lcc_pkg::A_STAT, r);
    `CHK("not yet", 1'b0, r[0])
    btn(1'b0, 25);
    `CHK("first ch", 64'hff, ch_level)
    y0 = led_yellow;
    tk(5);
    `CHK("blink", ~y0, led_yellow)
    btn(1'b1, 30);
    btn(1'b0, 25);
    `CHK("next ch", 64'hff00, ch_level)
    btn(1'b1, 70);
    `CHK("green back", 1'b1, led_green)
    btn(1'b0, 25);
    rd_reg(lcc_pkg::A_STAT, r);
    `CHK("test end", 1'b0, r[0])
    `CHK("restore", {lvl, 8'h55}, ch_level[1:0])
    btn(1'b1, 70);
    btn(1'b0, 25);
    cmd(lcc_pkg::CMD_SETVAL, 7, 8'h33);
    `CHK("hidden", 8'h00, ch_level[7])
    tk(210);
    rd_reg(lcc_pkg::A_STAT, r);
    `CHK("idle exit", 1'b0, r[0])
    `CHK("resumed", 8'h33, ch_level[7])
    done("test mode");

    wr_reg(lcc_pkg::A_CTRL, 32'h40);
    cmd(lcc_pkg::CMD_SETVAL, 6, 8'h90);
    `CHK("dynamic setval", 8'h00, ch_level[6])
    done("dynamic");

    cmd(lcc_pkg::CMD_CDIM, 0, 8'h09);
    tk(45);
    cmd(lcc_pkg::CMD_CDIM, 0, 8'h08);
    `CHK("cdim up ch0", 1'b1, ch_level[0] > 8'h55)
    `CHK("cdim up ch3", 1'b1, ch_level[3] > 8'h00)
    `CHK("cdim dyn", 8'h00, ch_level[6])
    done("central dim");
    wrap_up;
  end
endmodule : lighting_channel_controller_tb
